/* design/port_pin_override_mux_defines.svh */
// constant macros for the port pin override multiplexer
// assumes a byte-wide wishbone register map on 32-bit words
`ifndef PORT_PIN_OVERRIDE_MUX_DEFINES_SVH
`define PORT_PIN_OVERRIDE_MUX_DEFINES_SVH
// ==========================================
// register byte addresses
`define ADDR_MCU_CONTROL 4'h0
`define ADDR_PORT_DIR    4'h4
`define ADDR_PORT_LATCH  4'h8
`define ADDR_PORT_INPUT  4'hC
// ==========================================
// field positions and reset values
`define MCU_PUD_BIT      7
`define MCU_CONTROL_RST  8'h00
`define PORT_DIR_RST     8'h00
`define PORT_LATCH_RST   8'h00
// ==========================================
// port b pin assignments
`define PB_SERIAL_CLOCK  7
`define PB_SERIAL_DOUT   6
`define PB_SERIAL_DIN    5
`define PB_TIMER1_CMPB   4
`define PB_TIMER1_CMPA   3
`define PB_TIMER0_CMPA   2
`endif

/* design/port_pin_override_mux_pkg.sv */
// types shared by the port pin override multiplexer files
// assumes nothing beyond a systemverilog tool
package port_pin_override_mux_pkg;
  // ==========================================
  // register index decoded from the bus address
  typedef enum logic [1:0]
  {
    REG_MCU   = 2'b00,
    REG_DIR   = 2'b01,
    REG_LATCH = 2'b10,
    REG_INPUT = 2'b11
  } reg_sel_e;
endpackage

/* design/pin_ctrl_cell.sv */
// one pin of override logic: pull-up, driver, output value, input enable
// assumes all override inputs are synchronous to the block clock
`timescale 1ns/1ps
module pin_ctrl_cell
(
  input  wire logic dir_bit_in,
  input  wire logic latch_bit_in,
  input  wire logic pud_in,
  input  wire logic sleep_clamp_in,
  input  wire logic pullup_override_en_in,
  input  wire logic pullup_override_val_in,
  input  wire logic dir_override_en_in,
  input  wire logic dir_override_val_in,
  input  wire logic out_value_override_en_in,
  input  wire logic out_value_override_val_in,
  input  wire logic input_enable_override_en_in,
  input  wire logic input_enable_override_val_in,
  input  wire logic pad_in,
  output logic      pullup_out,
  output logic      drive_en_out,
  output logic      drive_val_out,
  output logic      digital_in_out
);
  logic input_enable;
  // ==========================================
  // pull-up: override wins, else only input with latch high and no global disable
  assign pullup_out = pullup_override_en_in ? pullup_override_val_in
                    : ({dir_bit_in, latch_bit_in, pud_in} == 3'b010);
  // output driver enable
  assign drive_en_out = dir_override_en_in ? dir_override_val_in
                      : dir_bit_in;
  // driven level; meaningful only while the driver is on
  assign drive_val_out = out_value_override_en_in ? out_value_override_val_in
                       : latch_bit_in;
  // sleep clamps the schmitt input to zero unless a module overrides it
  assign input_enable = input_enable_override_en_in ? input_enable_override_val_in
                      : ~sleep_clamp_in;
  // unsynchronised input for modules, taken before the port synchroniser
  assign digital_in_out = pad_in & input_enable;
endmodule

/* design/pin_input_sync.sv */
// two-stage synchroniser for the port's readable input bits
// assumes one clock; the first stage feeds only the second
`timescale 1ns/1ps
module pin_input_sync
#(
  parameter int WIDTH = 8
)
(
  input  wire logic             clock_in,
  input  wire logic             reset_n_in,
  input  wire logic [WIDTH-1:0] data_in,
  output logic      [WIDTH-1:0] data_out
);
  logic [WIDTH-1:0] stage_one;
  // ==========================================
  // two flops; metastability settles in the first
  always_ff @(posedge clock_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      stage_one <= '0;
      data_out  <= '0;
    end
    else
    begin
      stage_one <= data_in;
      data_out  <= stage_one;
    end
  end
endmodule

/* design/port_pin_override_mux.sv */
// port b pin override multiplexer with wishbone register access
// assumes peripheral override signals are synchronous to clock_in
//
// Behaviour
// - pull-up override enable selects override value, ignoring direction, latch, disable
// - without override, pull-up on only when direction,latch,disable equal 010
// - direction override enable makes driver enable follow the override value
// - without direction override, driver enabled exactly when direction bit is one
// - value override enable with driver on drives override value to pin
// - without value override, enabled driver drives the output latch bit
// - toggle override enable from a module inverts the output latch bit
// - input enable follows override value, else normal or sleep clamp
// - modules get digital input before the port synchroniser
// - port strobes shared per port; clock, sleep, pull-up disable shared
// - control bit 7 set disables every pull-up, even input-with-pull-up pins
// - three-wire serial output replaces bit 6 latch, driven only if direction one
// - serial output pin as input keeps latch-controlled pull-up
// - bit 7 is serial clock in three-wire and two-wire modes
// - bit 4 carries timer1 compare b output only when set as output
// - each port b pin n is pin-change source n
// - direction one makes output, zero input; latch gives driven level
// - writing one to input register bit inverts the latch bit
`timescale 1ns/1ps
`include "port_pin_override_mux_defines.svh"
module port_pin_override_mux
#(
  parameter int PINS = 8
)
(
  input  wire logic            clock_in,
  input  wire logic            reset_n_in,
  // wishbone classic slave
  input  wire logic            wb_cyc_in,
  input  wire logic            wb_stb_in,
  input  wire logic            wb_we_in,
  input  wire logic [3:0]      wb_adr_in,
  input  wire logic [3:0]      wb_sel_in,
  input  wire logic [31:0]     wb_dat_in,
  output logic      [31:0]     wb_dat_out,
  output logic                 wb_ack_out,
  // shared across all ports
  input  wire logic            sleep_clamp_in,
  output logic                 global_pullup_disable_out,
  // serial interface overrides
  input  wire logic            serial_three_wire_in,
  input  wire logic            serial_two_wire_in,
  input  wire logic            serial_data_out_in,
  input  wire logic            serial_clock_hold_in,
  input  wire logic            serial_toggle_in,
  input  wire logic            serial_start_ie_in,
  // timer compare overrides
  input  wire logic            timer1_compare_b_en_in,
  input  wire logic            timer1_compare_b_out_in,
  input  wire logic            timer1_compare_a_en_in,
  input  wire logic            timer1_compare_a_out_in,
  input  wire logic            timer0_compare_a_en_in,
  input  wire logic            timer0_compare_a_out_in,
  // pin change enables
  input  wire logic            pin_change_ie_in,
  input  wire logic [PINS-1:0] pin_change_mask_in,
  // pad side
  input  wire logic [PINS-1:0] pad_in,
  output logic      [PINS-1:0] pad_out,
  output logic      [PINS-1:0] pad_oe_out,
  output logic      [PINS-1:0] pad_pullup_out,
  // module side
  output logic      [PINS-1:0] alt_digital_input_out,
  output logic      [PINS-1:0] pin_change_src_out
);
  logic [7:0]      mcu_control;
  logic [PINS-1:0] pin_direction_bit;
  logic [PINS-1:0] pin_output_latch_bit;
  logic [PINS-1:0] pin_input_bit;
  logic [PINS-1:0] next_latch;
  logic [PINS-1:0] toggle_override_en;
  logic [PINS-1:0] pullup_override_en;
  logic [PINS-1:0] pullup_override_val;
  logic [PINS-1:0] dir_override_en;
  logic [PINS-1:0] dir_override_val;
  logic [PINS-1:0] out_value_override_en;
  logic [PINS-1:0] out_value_override_val;
  logic [PINS-1:0] input_enable_override_en;
  logic [PINS-1:0] input_enable_override_val;
  logic [PINS-1:0] drive_en;
  logic [PINS-1:0] drive_val;
  logic [PINS-1:0] digital_in;
  logic            bus_req;
  logic            wr_mcu;
  logic            wr_dir;
  logic            wr_latch;
  logic            wr_input;

  // ==========================================
  // bus decode
  function automatic port_pin_override_mux_pkg::reg_sel_e reg_of(input logic [3:0] adr);
    reg_of = port_pin_override_mux_pkg::reg_sel_e'(adr[3:2]);
  endfunction

  // request is seen while ack is low, so each access is answered once
  assign bus_req  = wb_cyc_in & wb_stb_in & ~wb_ack_out;
  // the port's write strobes are common to all its pins
  assign wr_mcu   = bus_req & wb_we_in & wb_sel_in[0]
                  & (reg_of(wb_adr_in) == port_pin_override_mux_pkg::REG_MCU);
  assign wr_dir   = bus_req & wb_we_in & wb_sel_in[0]
                  & (reg_of(wb_adr_in) == port_pin_override_mux_pkg::REG_DIR);
  assign wr_latch = bus_req & wb_we_in & wb_sel_in[0]
                  & (reg_of(wb_adr_in) == port_pin_override_mux_pkg::REG_LATCH);
  assign wr_input = bus_req & wb_we_in & wb_sel_in[0]
                  & (reg_of(wb_adr_in) == port_pin_override_mux_pkg::REG_INPUT);

  // ==========================================
  // ack one cycle after the request, dropped the next cycle
  always_ff @(posedge clock_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      wb_ack_out <= 1'b0;
    else
      wb_ack_out <= bus_req;
  end

  // read data registered; all four word slots are mapped, upper bits zero
  always_ff @(posedge clock_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      wb_dat_out <= 32'h0000_0000;
    else if (bus_req && !wb_we_in)
    begin
      unique case (reg_of(wb_adr_in))
        port_pin_override_mux_pkg::REG_MCU:   wb_dat_out <= {24'h000000, mcu_control};
        port_pin_override_mux_pkg::REG_DIR:   wb_dat_out <= {24'h000000, pin_direction_bit};
        port_pin_override_mux_pkg::REG_LATCH: wb_dat_out <= {24'h000000, pin_output_latch_bit};
        port_pin_override_mux_pkg::REG_INPUT: wb_dat_out <= {24'h000000, pin_input_bit};
      endcase
    end
  end

  // ==========================================
  // control register; only the pull-up disable bit steers this block
  always_ff @(posedge clock_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      mcu_control <= `MCU_CONTROL_RST;
    else if (wr_mcu)
      mcu_control <= wb_dat_in[7:0];
  end
  assign global_pullup_disable_out = mcu_control[`MCU_PUD_BIT];

  // direction register
  always_ff @(posedge clock_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      pin_direction_bit <= `PORT_DIR_RST;
    else if (wr_dir)
      pin_direction_bit <= wb_dat_in[PINS-1:0];
  end

  // latch: a write loads, ones to the input address toggle, modules toggle too;
  // write and toggle in one cycle give the toggle applied to the written value
  always_comb
  begin
    next_latch = pin_output_latch_bit;
    if (wr_latch)
      next_latch = wb_dat_in[PINS-1:0];
    if (wr_input)
      next_latch = next_latch ^ wb_dat_in[PINS-1:0];
    next_latch = next_latch ^ toggle_override_en;
  end

  always_ff @(posedge clock_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      pin_output_latch_bit <= `PORT_LATCH_RST;
    else
      pin_output_latch_bit <= next_latch;
  end

  // ==========================================
  // per-pin override sources for port b
  always_comb
  begin
    pullup_override_en        = '0;
    pullup_override_val       = '0;
    dir_override_en           = '0;
    dir_override_val          = '0;
    out_value_override_en     = '0;
    out_value_override_val    = '0;
    toggle_override_en        = '0;
    input_enable_override_en  = '0;
    input_enable_override_val = '1;
    // pin change sources keep their input alive in sleep
    input_enable_override_en  = pin_change_mask_in & {PINS{pin_change_ie_in}};
    // serial clock: three-wire clock, two-wire clock line with hold
    dir_override_en[`PB_SERIAL_CLOCK]       = serial_two_wire_in;
    dir_override_val[`PB_SERIAL_CLOCK]      = (serial_clock_hold_in
      | pin_output_latch_bit[`PB_SERIAL_CLOCK]) & pin_direction_bit[`PB_SERIAL_CLOCK];
    out_value_override_en[`PB_SERIAL_CLOCK] = serial_two_wire_in
      & pin_direction_bit[`PB_SERIAL_CLOCK];
    toggle_override_en[`PB_SERIAL_CLOCK]    = serial_toggle_in;
    input_enable_override_en[`PB_SERIAL_CLOCK] =
      input_enable_override_en[`PB_SERIAL_CLOCK] | serial_start_ie_in;
    // serial data out replaces the latch; direction bit still gates the driver
    out_value_override_en[`PB_SERIAL_DOUT]  = serial_three_wire_in;
    out_value_override_val[`PB_SERIAL_DOUT] = serial_data_out_in;
    // two-wire data line; three-wire receive relies on software making it input
    dir_override_en[`PB_SERIAL_DIN]         = serial_two_wire_in;
    dir_override_val[`PB_SERIAL_DIN]        = (pad_in[`PB_SERIAL_DIN]
      | pin_output_latch_bit[`PB_SERIAL_DIN]) & pin_direction_bit[`PB_SERIAL_DIN];
    out_value_override_en[`PB_SERIAL_DIN]   = serial_two_wire_in
      & pin_direction_bit[`PB_SERIAL_DIN];
    input_enable_override_en[`PB_SERIAL_DIN] =
      input_enable_override_en[`PB_SERIAL_DIN] | serial_start_ie_in;
    // timer compare outputs; driver still needs the direction bit
    out_value_override_en[`PB_TIMER1_CMPB]  = timer1_compare_b_en_in;
    out_value_override_val[`PB_TIMER1_CMPB] = timer1_compare_b_out_in;
    out_value_override_en[`PB_TIMER1_CMPA]  = timer1_compare_a_en_in;
    out_value_override_val[`PB_TIMER1_CMPA] = timer1_compare_a_out_in;
    out_value_override_en[`PB_TIMER0_CMPA]  = timer0_compare_a_en_in;
    out_value_override_val[`PB_TIMER0_CMPA] = timer0_compare_a_out_in;
  end

  // ==========================================
  // one combinational cell per pin, so overrides act in the same cycle
  generate
    for (genvar i = 0; i < PINS; i++)
    begin : g_pin
      pin_ctrl_cell u_cell
      (
        .dir_bit_in                   (pin_direction_bit[i]),
        .latch_bit_in                 (pin_output_latch_bit[i]),
        .pud_in                       (global_pullup_disable_out),
        .sleep_clamp_in               (sleep_clamp_in),
        .pullup_override_en_in        (pullup_override_en[i]),
        .pullup_override_val_in       (pullup_override_val[i]),
        .dir_override_en_in           (dir_override_en[i]),
        .dir_override_val_in          (dir_override_val[i]),
        .out_value_override_en_in     (out_value_override_en[i]),
        .out_value_override_val_in    (out_value_override_val[i]),
        .input_enable_override_en_in  (input_enable_override_en[i]),
        .input_enable_override_val_in (input_enable_override_val[i]),
        .pad_in                       (pad_in[i]),
        .pullup_out                   (pad_pullup_out[i]),
        .drive_en_out                 (drive_en[i]),
        .drive_val_out                (drive_val[i]),
        .digital_in_out               (digital_in[i])
      );
    end
  endgenerate

  // pad drive: level only meaningful where enabled, held low otherwise
  assign pad_oe_out            = drive_en;
  assign pad_out               = drive_val & drive_en;
  assign alt_digital_input_out = digital_in;
  assign pin_change_src_out    = digital_in;

  // readable pin value through the port synchroniser
  pin_input_sync #(.WIDTH(PINS)) u_sync
  (
    .clock_in   (clock_in),
    .reset_n_in (reset_n_in),
    .data_in    (digital_in),
    .data_out   (pin_input_bit)
  );

  // ==========================================
  // checks
  a_pud_kills_pullup: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    (global_pullup_disable_out && pullup_override_en == '0) |-> pad_pullup_out == '0)
    else $error("pull-up on with global disable set");
  a_dir_drives_oe: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    (dir_override_en == '0) |-> pad_oe_out == pin_direction_bit)
    else $error("driver enable differs from direction");
  a_input_pullup_on: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    (!global_pullup_disable_out && !pin_direction_bit[0] && pin_output_latch_bit[0])
    |-> pad_pullup_out[0])
    else $error("pull-up missing on input pin 0");
  a_serial_dout_pin: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    (serial_three_wire_in && pin_direction_bit[6]) |-> pad_out[6] == serial_data_out_in)
    else $error("serial data out not on pin 6");
  a_timer_b_gated: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    !pin_direction_bit[4] |-> !pad_oe_out[4])
    else $error("compare b driven while input");
  a_latch_toggle_write: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    (wr_input && !wr_latch && toggle_override_en == '0)
    |=> pin_output_latch_bit == ($past(pin_output_latch_bit) ^ $past(wb_dat_in[PINS-1:0])))
    else $error("input write did not toggle latch");
  a_ack_one_cycle: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    (wb_cyc_in && wb_stb_in && !wb_ack_out) |=> wb_ack_out ##1 !wb_ack_out)
    else $error("ack not a single cycle pulse");
  a_sync_delay: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    1'b1 |-> ##2 pin_input_bit == $past(digital_in, 2))
    else $error("pin input not two cycles behind");
endmodule

/* testbench/pad_world_model.sv */
// far side of the port: external pins seen by the pads
// assumes pad outputs are combinational and the bench may drive pins itself
`timescale 1ns/1ps
module pad_world_model
(
  input  wire logic       clock_in,
  input  wire logic [7:0] pad_out_in,
  input  wire logic [7:0] pad_oe_in,
  input  wire logic [7:0] pad_pullup_in,
  input  wire logic [7:0] ext_en_in,
  input  wire logic [7:0] ext_lvl_in,
  output logic      [7:0] pad_level_out
);
  // ==========================================
  // floating pins
  logic [7:0] float_pat = 8'hA5;
  // an undriven pin without pull-up wanders, so stale values never pass
  always @(posedge clock_in)
    float_pat <= ~float_pat;
  // external driver wins, then our own driver, then pull-up, then float
  assign pad_level_out = (ext_en_in & ext_lvl_in)
                       | (~ext_en_in & pad_oe_in & pad_out_in)
                       | (~ext_en_in & ~pad_oe_in & (pad_pullup_in | float_pat));
endmodule

/* testbench/tb_top.sv */
// self-checking bench for the port b override multiplexer
// assumes a wishbone slave answering with a one-cycle ack
`timescale 1ns/1ps
module tb_top;
  // ==========================================
  // signals
  logic        clock_in, reset_n_in, wb_cyc_in, wb_stb_in, wb_we_in, wb_ack_out;
  logic [3:0]  wb_adr_in, wb_sel_in;
  logic [31:0] wb_dat_in, wb_dat_out;
  logic        sleep_clamp_in, gpd, three_w, two_w, sdo, shold, stog, sie;
  logic        t1b_en, t1b_v, t1a_en, t1a_v, t0a_en, t0a_v, pc_ie;
  logic [7:0]  pc_mask, pad_in, pad_out, pad_oe, pad_pu, alt_di, pc_src, ext_en, ext_lvl, rd;
  int          error_cnt = 0;
  int          checked = 0;
  // ==========================================
  // clock and instances
  initial
  begin
    clock_in = 1'b0;
    forever #12.5 clock_in = ~clock_in;
  end
  port_pin_override_mux port_pin_override_mux_i (.clock_in(clock_in), .reset_n_in(reset_n_in),
    .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in),
    .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in), .wb_dat_out(wb_dat_out),
    .wb_ack_out(wb_ack_out), .sleep_clamp_in(sleep_clamp_in), .global_pullup_disable_out(gpd),
    .serial_three_wire_in(three_w), .serial_two_wire_in(two_w), .serial_data_out_in(sdo),
    .serial_clock_hold_in(shold), .serial_toggle_in(stog), .serial_start_ie_in(sie),
    .timer1_compare_b_en_in(t1b_en), .timer1_compare_b_out_in(t1b_v),
    .timer1_compare_a_en_in(t1a_en), .timer1_compare_a_out_in(t1a_v),
    .timer0_compare_a_en_in(t0a_en), .timer0_compare_a_out_in(t0a_v),
    .pin_change_ie_in(pc_ie), .pin_change_mask_in(pc_mask), .pad_in(pad_in),
    .pad_out(pad_out), .pad_oe_out(pad_oe), .pad_pullup_out(pad_pu),
    .alt_digital_input_out(alt_di), .pin_change_src_out(pc_src));
  pad_world_model pad_world_model_i (.clock_in(clock_in), .pad_out_in(pad_out),
    .pad_oe_in(pad_oe), .pad_pullup_in(pad_pu), .ext_en_in(ext_en), .ext_lvl_in(ext_lvl),
    .pad_level_out(pad_in));
  // ==========================================
  // shared tasks
  task automatic results();
    $display("counts: checked=%0d error_cnt=%0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one classic cycle; holds everything until ack is sampled high
  task automatic wb(input logic we, input logic [3:0] adr, input logic [7:0] dat);
    int n;
    @(posedge clock_in);
    wb_cyc_in <= 1'b1;
    wb_stb_in <= 1'b1;
    wb_we_in  <= we;
    wb_adr_in <= adr;
    wb_dat_in <= {24'h000000, dat};
    for (n = 0; n < 20 && wb_ack_out !== 1'b1; n++)
      @(posedge clock_in);
    if (n == 20)
    begin
      error_cnt++;
      results();
    end
    rd = wb_dat_out[7:0];
    wb_cyc_in <= 1'b0;
    wb_stb_in <= 1'b0;
    #1;
  endtask
  task automatic edge_wait();
    @(posedge clock_in);
  endtask
  // ==========================================
  // scenarios
  task automatic t_reset();
    wb(1'b0, 4'h0, 8'h00); chk(rd, 8'h00);
    wb(1'b0, 4'h4, 8'h00); chk(rd, 8'h00);
    wb(1'b0, 4'h8, 8'h00); chk(rd, 8'h00);
    chk(pad_oe, 8'h00);
    chk(pad_pu, 8'h00);
    $display("test reset done");
  endtask
  task automatic t_pullup();
    wb(1'b1, 4'h4, 8'h0F);
    wb(1'b1, 4'h8, 8'h33);
    chk(pad_pu, 8'h30);
    chk(pad_oe, 8'h0F);
    chk(pad_out, 8'h03);
    wb(1'b1, 4'h0, 8'h80);
    chk(pad_pu, 8'h00);
    chk({7'h00, gpd}, 8'h01);
    wb(1'b0, 4'h0, 8'h00); chk(rd, 8'h80);
    wb(1'b1, 4'h0, 8'h00);
    chk(pad_pu, 8'h30);
    $display("test pullup done");
  endtask
  task automatic t_toggle();
    wb(1'b1, 4'hC, 8'h81);
    wb(1'b0, 4'h8, 8'h00); chk(rd, 8'hB2);
    edge_wait();
    stog <= 1'b1;
    edge_wait();
    stog <= 1'b0;
    wb(1'b0, 4'h8, 8'h00); chk(rd, 8'h32);
    $display("test toggle done");
  endtask
  task automatic t_timer();
    wb(1'b1, 4'h8, 8'h00);
    wb(1'b1, 4'h4, 8'h1C);
    edge_wait();
    {t1b_en, t1a_en, t0a_en} <= 3'b111;
    {t1b_v, t1a_v, t0a_v} <= 3'b101;
    #1;
    chk(pad_out, 8'h14);
    wb(1'b1, 4'h4, 8'h00);
    chk(pad_oe, 8'h00);
    chk(pad_out, 8'h00);
    edge_wait();
    {t1b_en, t1a_en, t0a_en} <= 3'b000;
    $display("test timer done");
  endtask
  task automatic t_serial();
    wb(1'b1, 4'h4, 8'h40);
    edge_wait();
    three_w <= 1'b1;
    sdo <= 1'b1;
    #1;
    chk(pad_out, 8'h40);
    edge_wait();
    sdo <= 1'b0;
    #1;
    chk(pad_out, 8'h00);
    edge_wait();
    sdo <= 1'b1;
    wb(1'b1, 4'h4, 8'h00);
    wb(1'b1, 4'h8, 8'h40);
    chk(pad_oe, 8'h00);
    chk(pad_pu, 8'h40);
    chk(pad_out, 8'h00);
    edge_wait();
    three_w <= 1'b0;
    wb(1'b1, 4'h8, 8'h80);
    wb(1'b1, 4'h4, 8'h80);
    chk(pad_out, 8'h80);
    edge_wait();
    two_w <= 1'b1;
    #1;
    chk(pad_out & 8'h80, 8'h00);
    chk(pad_oe & 8'h80, 8'h80);
    // clock line released once latch and hold are both low
    wb(1'b1, 4'h8, 8'h00);
    chk(pad_oe & 8'h80, 8'h00);
    edge_wait();
    shold <= 1'b1;
    #1;
    chk(pad_oe & 8'h80, 8'h80);
    edge_wait();
    two_w <= 1'b0;
    shold <= 1'b0;
    $display("test serial done");
  endtask
  task automatic t_input();
    wb(1'b1, 4'h4, 8'h00);
    wb(1'b1, 4'h8, 8'h00);
    edge_wait();
    ext_en <= 8'hFF;
    ext_lvl <= 8'hA5;
    #1;
    chk(alt_di, 8'hA5);
    repeat (3) edge_wait();
    wb(1'b0, 4'hC, 8'h00); chk(rd, 8'hA5);
    edge_wait();
    sleep_clamp_in <= 1'b1;
    pc_ie <= 1'b1;
    pc_mask <= 8'h0F;
    #1;
    chk(alt_di, 8'h05);
    chk(pc_src, 8'h05);
    edge_wait();
    pc_ie <= 1'b0;
    sie <= 1'b1;
    #1;
    chk(alt_di, 8'hA0);
    edge_wait();
    sie <= 1'b0;
    sleep_clamp_in <= 1'b0;
    #1;
    chk(pc_src, 8'hA5);
    $display("test input done");
  endtask
  // ==========================================
  // main sequence and watchdog
  initial
  begin
    {reset_n_in, wb_cyc_in, wb_stb_in, wb_we_in, sleep_clamp_in, three_w, two_w} = '0;
    {sdo, shold, stog, sie, t1b_en, t1b_v, t1a_en, t1a_v, t0a_en, t0a_v, pc_ie} = '0;
    wb_adr_in = 4'h0;
    wb_sel_in = 4'hF;
    wb_dat_in = 32'h00000000;
    pc_mask = 8'h00;
    ext_en = 8'h00;
    ext_lvl = 8'h00;
    repeat (10) edge_wait();
    reset_n_in <= 1'b1;
    t_reset();
    t_pullup();
    t_toggle();
    t_timer();
    t_serial();
    t_input();
    results();
  end
  initial
  begin
    #(25 * 20000);
    error_cnt++;
    results();
  end
endmodule
